// ==== design/usf_flags.sv ====
// Status-flag logic of one asynchronous serial channel behind an APB slave.
// Assumes received characters arrive already framed, one cycle pulse each,
// with their framing and parity verdicts; everything is on clk_i.
//
// How it works
// - Loading a received character into the receive buffer sets the buffer-full flag.
// - A receive data read clears buffer-full if the last status read showed it set.
// - Buffer-full that rose after the status read survives the next data read.
// - A finished transmission with no character waiting clears the busy flag.
// - Starting a transmission after a buffer write sets busy and raises a tx request.
// - Buffer-full is low while empty and clears, with a tx request, when shifting starts.
// - A software write to the transmit buffer sets the transmit buffer-full flag.
// - Buffer-full low with overrun high is a reachable state.
// - Error and overrun flags describe the buffered character and lost characters.
// - An infrared pulse lasts three sixteenths of a bit period; above baud divisor 0 the start-bit pulse can be shorter.
// - A character completing while the buffer is full sets overrun and a rx request.
// - Overrun drops the new character; later ones are dropped silently while it stands.
//
// Added by the designer: the register addresses and register access over APB.
module usf_flags
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Received characters from the frame sampler
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_char_i,
    input  wire logic        rx_framing_err_i,
    input  wire logic        rx_parity_err_i,
    // Line and interrupt
    output logic             txd_o,
    output logic             irq_o
);
    // Flags and buffers
    logic                          rx_buffer_full_flag_r;
    logic                          overrun_flag_r;
    logic                          framing_error_flag_r;
    logic                          parity_error_flag_r;
    logic                          tx_busy_flag_r;
    logic                          tx_buffer_full_flag_r;
    logic [7:0]                    rx_data_buffer_r;
    logic [7:0]                    tx_data_buffer_r;
    logic                          seen_rx_buffer_full_flag_r;
    logic                          seen_overrun_flag_r;
    logic                          ir_en_r;
    logic [15:0]                   baud_r;
    logic [15:0]                   div_r;
    logic                          tick_r;
    logic [usf_pkg::INT_BITS-1:0]  int_status_r;
    logic [usf_pkg::INT_BITS-1:0]  int_enable_r;
    logic [31:0]                   prdata_r;
    logic                          pready_r;
    logic                          pslverr_r;
    logic                          irq_r;
    logic                          txd_r;
    logic                          start_r;
    logic [7:0]                    shift_data_r;

    // Bus decode
    logic setup;
    logic access;
    logic wr_txdata;
    logic rd_status;
    logic rd_rxdata;
    logic clr_rx_buffer_full_flag;
    logic clr_overrun_flag;
    logic rx_accept;
    logic rx_overrun;
    logic rx_irq_req;
    logic tx_irq_req;
    logic [31:0] rd_val;
    logic [5:0]  status_val;

    usf_tx_if tx ();

    assign setup     = psel_i && !penable_i;
    assign access    = psel_i && penable_i && pready_r && !pslverr_r;
    assign wr_txdata = access && pwrite_i && (paddr_i == usf_pkg::ADDR_TXDATA);
    assign rd_status = access && !pwrite_i && (paddr_i == usf_pkg::ADDR_STATUS);
    assign rd_rxdata = access && !pwrite_i && (paddr_i == usf_pkg::ADDR_RXDATA);

    // Clears are qualified by what the previous status read showed
    assign clr_rx_buffer_full_flag = rd_rxdata && seen_rx_buffer_full_flag_r;
    assign clr_overrun_flag = rd_rxdata && seen_overrun_flag_r;

    // A read that empties the buffer in the same cycle lets the new character in
    assign rx_accept  = rx_valid_i && !overrun_flag_r
                        && (!rx_buffer_full_flag_r || clr_rx_buffer_full_flag);
    assign rx_overrun = rx_valid_i && !rx_accept;
    assign rx_irq_req = rx_accept || (rx_overrun && !overrun_flag_r);
    assign tx_irq_req = start_r;

    // Status image
    always_comb
    begin
        status_val = 6'h00;
        status_val[usf_pkg::ST_RX_BUFFER_FULL_FLAG] = rx_buffer_full_flag_r;
        status_val[usf_pkg::ST_OVERRUN_FLAG] = overrun_flag_r;
        status_val[usf_pkg::ST_FRAMING_ERROR_FLAG] = framing_error_flag_r;
        status_val[usf_pkg::ST_PARITY_ERROR_FLAG] = parity_error_flag_r;
        status_val[usf_pkg::ST_TX_BUSY_FLAG] = tx_busy_flag_r;
        status_val[usf_pkg::ST_TX_BUFFER_FULL_FLAG] = tx_buffer_full_flag_r;
    end

    // Read mux; unmapped and write-only offsets read as zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (paddr_i)
            usf_pkg::ADDR_STATUS: rd_val = {26'h0, status_val};
            usf_pkg::ADDR_RXDATA: rd_val = {24'h0, rx_data_buffer_r};
            usf_pkg::ADDR_CTRL:   rd_val = {31'h0, ir_en_r};
            usf_pkg::ADDR_BAUD:   rd_val = {16'h0, baud_r};
            usf_pkg::ADDR_INTST:  rd_val = {30'h0, int_status_r};
            usf_pkg::ADDR_INTEN:  rd_val = {30'h0, int_enable_r};
            default:              rd_val = 32'h0000_0000;
        endcase
    end

    // APB answer: data captured in setup, ready in the single access cycle
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup;
            if (setup)
            begin
                prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_val;
                pslverr_r <= (paddr_i[1:0] != 2'h0) || (paddr_i > usf_pkg::ADDR_INTCLR);
            end
            else if (!psel_i)
                pslverr_r <= 1'b0;
        end
    end

    // Control registers written by software
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ir_en_r      <= 1'b0;
            baud_r       <= usf_pkg::BAUD_RST;
            int_enable_r <= '0;
        end
        else if (access && pwrite_i)
        begin
            if (paddr_i == usf_pkg::ADDR_CTRL)
                ir_en_r <= pwdata_i[usf_pkg::CTRL_IR];
            if (paddr_i == usf_pkg::ADDR_BAUD)
                baud_r <= pwdata_i[15:0];
            if (paddr_i == usf_pkg::ADDR_INTEN)
                int_enable_r <= pwdata_i[usf_pkg::INT_BITS-1:0];
        end
    end

    // 16x bit-clock enable; the period is baud_r + 1 system cycles
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            div_r  <= 16'h0000;
            tick_r <= 1'b0;
        end
        else if (div_r >= baud_r)
        begin
            div_r  <= 16'h0000;
            tick_r <= 1'b1;
        end
        else
        begin
            div_r  <= div_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // Snapshot of the flags as the status read returned them
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            seen_rx_buffer_full_flag_r <= 1'b0;
            seen_overrun_flag_r <= 1'b0;
        end
        else if (rd_status)
        begin
            seen_rx_buffer_full_flag_r <= prdata_r[usf_pkg::ST_RX_BUFFER_FULL_FLAG];
            seen_overrun_flag_r <= prdata_r[usf_pkg::ST_OVERRUN_FLAG];
        end
        else if (rd_rxdata)
        begin
            seen_rx_buffer_full_flag_r <= 1'b0;
            seen_overrun_flag_r <= 1'b0;
        end
    end

    // Receive buffer and its flags; a new load wins over a clear
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_buffer_full_flag_r <= 1'b0;
            framing_error_flag_r  <= 1'b0;
            parity_error_flag_r   <= 1'b0;
            rx_data_buffer_r      <= 8'h00;
        end
        else if (rx_accept)
        begin
            rx_buffer_full_flag_r <= 1'b1;
            framing_error_flag_r  <= rx_framing_err_i;
            parity_error_flag_r   <= rx_parity_err_i;
            rx_data_buffer_r      <= rx_char_i;
        end
        else if (clr_rx_buffer_full_flag)
        begin
            rx_buffer_full_flag_r <= 1'b0;
            framing_error_flag_r  <= 1'b0;
            parity_error_flag_r   <= 1'b0;
        end
    end

    // Overrun; dropped characters leave the error flags untouched
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            overrun_flag_r <= 1'b0;
        else if (rx_overrun)
            overrun_flag_r <= 1'b1;
        else if (clr_overrun_flag)
            overrun_flag_r <= 1'b0;
    end

    // Transmit buffer and flags; a write in the start cycle refills the buffer
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_buffer_full_flag_r <= 1'b0;
            tx_busy_flag_r        <= 1'b0;
            tx_data_buffer_r      <= usf_pkg::TXBUF_RST;
            start_r               <= 1'b0;
            shift_data_r          <= usf_pkg::TXBUF_RST;
        end
        else
        begin
            start_r <= 1'b0;
            if (wr_txdata)
            begin
                tx_data_buffer_r      <= pwdata_i[7:0];
                tx_buffer_full_flag_r <= 1'b1;
            end
            else if (tx_buffer_full_flag_r && !tx.busy && !start_r)
                tx_buffer_full_flag_r <= 1'b0;
            if (tx_buffer_full_flag_r && !tx.busy && !start_r)
            begin
                // Copy taken now so a write in this cycle cannot replace the outgoing character
                shift_data_r   <= tx_data_buffer_r;
                start_r        <= 1'b1;
                tx_busy_flag_r <= 1'b1;
            end
            else if (tx.done && !tx_buffer_full_flag_r)
                tx_busy_flag_r <= 1'b0;
        end
    end

    assign tx.tick  = tick_r;
    assign tx.ir_en = ir_en_r;
    assign tx.start = start_r;
    assign tx.data  = shift_data_r;

    usf_tx_shift u_shift
    (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .tx     (tx.shift)
    );

    // Sticky interrupt status; an event in the clear cycle survives
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            int_status_r <= '0;
        else
        begin
            if (access && pwrite_i && (paddr_i == usf_pkg::ADDR_INTCLR))
                int_status_r <= int_status_r & ~pwdata_i[usf_pkg::INT_BITS-1:0];
            if (rx_irq_req)
                int_status_r[usf_pkg::INT_RX] <= 1'b1;
            if (tx_irq_req)
                int_status_r[usf_pkg::INT_TX] <= 1'b1;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_r <= 1'b0;
            txd_r <= 1'b1;
        end
        else
        begin
            irq_r <= |(int_status_r & int_enable_r);
            txd_r <= tx.txd;
        end
    end

    assign prdata_o  = prdata_r;
    assign pready_o  = pready_r;
    assign pslverr_o = pslverr_r;
    assign irq_o     = irq_r;
    assign txd_o     = txd_r;

    // Checks on flag behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    chk_rx_buffer_full_flag_on_load: assert property (rx_accept |=> rx_buffer_full_flag_r)
        else $error("buffer full not set by load");
    chk_rx_buffer_full_flag_clear_seen: assert property (
        rd_rxdata && seen_rx_buffer_full_flag_r && !rx_accept |=> !rx_buffer_full_flag_r)
        else $error("buffer full not cleared by qualified read");
    chk_rx_buffer_full_flag_keep_unseen: assert property (
        rd_rxdata && !seen_rx_buffer_full_flag_r && rx_buffer_full_flag_r |=> rx_buffer_full_flag_r)
        else $error("buffer full cleared without status read");
    chk_tx_busy_flag_clear_done: assert property (
        tx.done && !tx_buffer_full_flag_r |=> !tx_busy_flag_r)
        else $error("busy not cleared after last frame");
    chk_start_irq: assert property (
        start_r && !$past(wr_txdata)
        |-> tx_busy_flag_r && !tx_buffer_full_flag_r ##1 int_status_r[usf_pkg::INT_TX])
        else $error("start did not set busy and tx request");
    chk_tx_buffer_full_flag_on_write: assert property (wr_txdata |=> tx_buffer_full_flag_r)
        else $error("tx buffer full not set by write");
    chk_tx_buffer_full_flag_start_wait: assert property (
        tx_buffer_full_flag_r && !tx.busy && !start_r && !wr_txdata
        |=> start_r && !tx_buffer_full_flag_r)
        else $error("buffered character not moved to shifter");
    chk_overrun_set: assert property (
        rx_valid_i && rx_buffer_full_flag_r && !clr_rx_buffer_full_flag
        |=> overrun_flag_r && $stable(rx_data_buffer_r))
        else $error("overrun not flagged or buffer overwritten");
    chk_overrun_silent: assert property (
        overrun_flag_r && rx_valid_i && !int_status_r[usf_pkg::INT_RX]
        && !(access && pwrite_i) |=> !int_status_r[usf_pkg::INT_RX])
        else $error("dropped character raised a request");
    chk_snap_matches: assert property (rd_status |=> seen_rx_buffer_full_flag_r == $past(prdata_r[0]))
        else $error("snapshot differs from returned status");
endmodule // usf_flags

// ==== design/usf_pkg.sv ====
// Package of the serial status-flag block: register map, field layout, frame timing.
// Assumes a 32-bit APB register bus with word-aligned registers.
package usf_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_RXDATA = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_CTRL   = 8'h0c;
    localparam logic [7:0] ADDR_BAUD   = 8'h10;
    localparam logic [7:0] ADDR_INTST  = 8'h14;
    localparam logic [7:0] ADDR_INTEN  = 8'h18;
    localparam logic [7:0] ADDR_INTCLR = 8'h1c;
    // Status register bit positions
    localparam int ST_RX_BUFFER_FULL_FLAG = 0;
    localparam int ST_OVERRUN_FLAG = 1;
    localparam int ST_FRAMING_ERROR_FLAG = 2;
    localparam int ST_PARITY_ERROR_FLAG = 3;
    localparam int ST_TX_BUSY_FLAG = 4;
    localparam int ST_TX_BUFFER_FULL_FLAG = 5;
    // Control and interrupt bit positions
    localparam int CTRL_IR  = 0;
    localparam int INT_RX   = 0;
    localparam int INT_TX   = 1;
    localparam int INT_BITS = 2;
    // Reset values
    localparam logic [15:0] BAUD_RST  = 16'h0000;
    localparam logic [7:0]  TXBUF_RST = 8'hff;
    // Frame timing: bit and pulse lengths in ticks of the 16x bit clock, frame length in bits
    localparam int TICKS_PER_BIT   = 16;
    localparam int IR_PULSE_TICKS  = 3;
    localparam int FRAME_BITS      = 10;
endpackage

// ==== design/usf_tx_if.sv ====
// Carrier between the flag logic and the transmit shifter.
// Assumes both ends share one clock; tick is a one-cycle enable.
interface usf_tx_if;
    logic       tick;
    logic       ir_en;
    logic       start;
    logic [7:0] data;
    logic       busy;
    logic       done;
    logic       txd;
    modport ctrl  (output tick, output ir_en, output start, output data,
                   input busy, input done, input txd);
    modport shift (input tick, input ir_en, input start, input data,
                   output busy, output done, output txd);
endinterface

// ==== design/usf_tx_shift.sv ====
// Transmit shift register with 8N1 framing and infrared pulse shaping.
// Assumes start only arrives while busy is low.
module usf_tx_shift
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Link to the flag logic
    usf_tx_if.shift   tx
);
    logic [9:0] frame_r;
    logic [3:0] bit_r;
    logic [3:0] tick_r;
    logic       busy_r;
    logic       done_r;
    logic       txd_r;

    // Frame progress, advanced once per 16x tick
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            frame_r <= 10'h3ff;
            bit_r   <= 4'h0;
            tick_r  <= 4'h0;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            if (tx.start && !busy_r)
            begin
                frame_r <= {1'b1, tx.data, 1'b0};
                bit_r   <= 4'h0;
                tick_r  <= 4'h0;
                busy_r  <= 1'b1;
            end
            else if (busy_r && tx.tick)
            begin
                tick_r <= tick_r + 4'h1;
                if (tick_r == 4'(usf_pkg::TICKS_PER_BIT - 1))
                begin
                    frame_r <= {1'b1, frame_r[9:1]};
                    if (bit_r == 4'(usf_pkg::FRAME_BITS - 1))
                    begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                    end
                    bit_r <= bit_r + 4'h1;
                end
            end
        end
    end

    // Line level; in infrared mode a zero bit is a short high pulse, idle is low
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            txd_r <= 1'b1;
        else if (!busy_r)
            txd_r <= !tx.ir_en;
        else if (tx.ir_en)
            txd_r <= !frame_r[0] && (tick_r < 4'(usf_pkg::IR_PULSE_TICKS));
        else
            txd_r <= frame_r[0];
    end

    assign tx.busy = busy_r;
    assign tx.done = done_r;
    assign tx.txd  = txd_r;

    // Infrared pulse never outlasts three ticks of the bit clock
    logic [4:0] ir_len_r;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ir_len_r <= 5'h00;
        else if (tx.ir_en && txd_r && busy_r)
            ir_len_r <= (tx.tick) ? ir_len_r + 5'h01 : ir_len_r;
        else
            ir_len_r <= 5'h00;
    end
    chk_ir_pulse_width: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ir_len_r <= 5'(usf_pkg::IR_PULSE_TICKS))
        else $error("infrared pulse longer than 3/16 bit");
endmodule // usf_tx_shift

// ==== bench/usf_line_peer.sv ====
// Far-side line model: hands over framed characters and decodes the 8N1 line.
// Assumes a baud divisor of 0 (16 clocks a bit) whenever listen_i is high.
module usf_line_peer
(
    // Clock
    input  wire logic       clk_i,
    // Line side
    input  wire logic       txd_i,
    input  wire logic       listen_i,
    // Character side
    output logic            rx_valid_o,
    output logic [7:0]      rx_char_o,
    output logic            rx_framing_err_o,
    output logic            rx_parity_err_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_char;
    int         frames;
    // Quiet until the first character
    initial
    begin
        rx_valid_o       = 1'b0;
        rx_char_o        = 8'h00;
        rx_framing_err_o = 1'b0;
        rx_parity_err_o  = 1'b0;
    end
    // One-cycle pulse; stale data is inverted so it cannot pass for valid
    task automatic send(input logic [7:0] c, input logic fe, input logic pe);
        @(posedge clk_i);
        rx_valid_o       <= 1'b1;
        rx_char_o        <= c;
        rx_framing_err_o <= fe;
        rx_parity_err_o  <= pe;
        @(posedge clk_i);
        rx_valid_o       <= 1'b0;
        rx_char_o        <= ~c;
        rx_framing_err_o <= ~fe;
        rx_parity_err_o  <= ~pe;
    endtask
    // Mid-bit sampling from the start edge; a bad stop bit drops the frame
    initial
    begin : decode
        logic [7:0] sh;
        frames = 0;
        forever
        begin
            @(posedge clk_i);
            if (listen_i && txd_i === 1'b0)
            begin
                repeat (8) @(posedge clk_i);
                for (int i = 0; i < 8; i++)
                begin
                    repeat (16) @(posedge clk_i);
                    sh[i] = txd_i;
                end
                repeat (16) @(posedge clk_i);
                if (txd_i === 1'b1)
                begin
                    last_char = sh;
                    frames++;
                end
            end
        end
    end
endmodule // usf_line_peer

// ==== bench/testbench.sv ====
// Self-checking bench of the serial status-flag block.
// Assumes the peer model drives the receive inputs and decodes txd_o.
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} usf_row_type;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        rx_valid_i;
    logic [7:0]  rx_char_i;
    logic        rx_framing_err_i;
    logic        rx_parity_err_i;
    logic        txd_o;
    logic        irq_o;
    logic        listen = 1'b1;
    int          err_total = 0;
    int          check_count = 0;
    logic [31:0] r;
    logic        e;
    int          n;
    // Reset values, read-only and write-only places, unmapped and misaligned addresses
    usf_row_type rows [9] = '{'{8'h00, 32'h0, 1'b0}, '{8'h04, 32'h0, 1'b0},
        '{8'h08, 32'h0, 1'b0}, '{8'h0c, 32'h0, 1'b0}, '{8'h10, 32'h0, 1'b0},
        '{8'h14, 32'h0, 1'b0}, '{8'h18, 32'h0, 1'b0}, '{8'h20, 32'h0, 1'b1},
        '{8'h02, 32'h0, 1'b1}};
    usf_flags dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i),
        .rx_char_i(rx_char_i), .rx_framing_err_i(rx_framing_err_i),
        .rx_parity_err_i(rx_parity_err_i), .txd_o(txd_o), .irq_o(irq_o));
    usf_line_peer peer_u (.clk_i(clk_i), .txd_i(txd_o), .listen_i(listen),
        .rx_valid_o(rx_valid_i), .rx_char_o(rx_char_i),
        .rx_framing_err_o(rx_framing_err_i), .rx_parity_err_o(rx_parity_err_i));
    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    // Verdict and end of run
    task automatic finish_test;
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int k;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (pready_o !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            err_total++;
            finish_test();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, d, x, y);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        logic        y;
        apb(1'b0, a, 32'h0, x, y);
        `CHK(nm, exp, x)
    endtask
    // Poll one status bit; polling is bounded since a frame is a few hundred cycles
    task automatic wait_st(input int b, input logic v);
        logic [31:0] x;
        logic        y;
        for (int k = 0; k < 300; k++)
        begin
            apb(1'b0, 8'h00, 32'h0, x, y);
            if (x[b] === v)
                return;
        end
        err_total++;
        finish_test();
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_i);
        `CHK("txd_reset", 1'b1, txd_o)
        rstn_i <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b0, rows[i].a, 32'h0, r, e);
            `CHK("pslverr", rows[i].e, e)
            if (!rows[i].e)
                `CHK("reset_value", rows[i].d, r)
        end
        wr(8'h18, 32'h3);
        peer_u.send(8'h5a, 1'b1, 1'b0);
        rd_chk("status_err", 8'h00, 32'h05);
        `CHK("irq_rx", 1'b1, irq_o)
        rd_chk("rxdata", 8'h04, 32'h5a);
        rd_chk("status_clr", 8'h00, 32'h0);
        wr(8'h1c, 32'h3);
        rd_chk("status_pre", 8'h00, 32'h0);
        peer_u.send(8'h11, 1'b0, 1'b0);
        rd_chk("rxdata_late", 8'h04, 32'h11);
        rd_chk("status_kept", 8'h00, 32'h01);
        rd_chk("rxdata_again", 8'h04, 32'h11);
        rd_chk("status_gone", 8'h00, 32'h0);
        wr(8'h1c, 32'h3);
        peer_u.send(8'h22, 1'b0, 1'b0);
        rd_chk("status_full", 8'h00, 32'h01);
        wr(8'h1c, 32'h1);
        peer_u.send(8'h33, 1'b0, 1'b1);
        rd_chk("int_overrun", 8'h14, 32'h1);
        wr(8'h1c, 32'h1);
        peer_u.send(8'h44, 1'b1, 1'b0);
        rd_chk("int_silent", 8'h14, 32'h0);
        `CHK("irq_silent", 1'b0, irq_o)
        rd_chk("rxdata_kept", 8'h04, 32'h22);
        rd_chk("status_ovr", 8'h00, 32'h02);
        rd_chk("rxdata_ovr", 8'h04, 32'h22);
        rd_chk("status_idle", 8'h00, 32'h0);
        wr(8'h18, 32'h0);
        peer_u.send(8'h55, 1'b0, 1'b0);
        rd_chk("int_masked", 8'h14, 32'h1);
        `CHK("irq_masked", 1'b0, irq_o)
        wr(8'h1c, 32'h3);
        rd_chk("status_rx", 8'h00, 32'h01);
        rd_chk("rxdata_rx", 8'h04, 32'h55);
        wr(8'h18, 32'h3);
        // Second write lands while the first character still shifts
        wr(8'h08, 32'ha5);
        wr(8'h08, 32'h3c);
        rd_chk("status_tx", 8'h00, 32'h30);
        rd_chk("int_tx", 8'h14, 32'h2);
        wr(8'h1c, 32'h2);
        wait_st(usf_pkg::ST_TX_BUFFER_FULL_FLAG, 1'b0);
        rd_chk("int_tx_move", 8'h14, 32'h2);
        wait_st(usf_pkg::ST_TX_BUSY_FLAG, 1'b0);
        repeat (20) @(posedge clk_i);
        `CHK("frames", 2, peer_u.frames)
        `CHK("line_char", 8'h3c, peer_u.last_char)
        // Infrared pulse width at two baud divisors
        listen <= 1'b0;
        wr(8'h0c, 32'h1);
        for (int b = 0; b < 2; b++)
        begin
            wr(8'h10, b);
            wr(8'h08, 32'h0);
            // First pulse depends on the divider phase at start; measure the second
            repeat (2)
            begin
                n = 0;
                while (txd_o !== 1'b1 && n < 2000)
                begin
                    @(posedge clk_i);
                    n++;
                end
                if (n >= 2000)
                begin
                    err_total++;
                    finish_test();
                end
                n = 0;
                while (txd_o === 1'b1 && n < 100)
                begin
                    @(posedge clk_i);
                    n++;
                end
            end
            `CHK("ir_pulse", usf_pkg::IR_PULSE_TICKS * (b + 1), n)
            wait_st(usf_pkg::ST_TX_BUSY_FLAG, 1'b0);
        end
        finish_test();
    end
endmodule // testbench
